// *** design/isea_pkg.sv ***
// Shared constants and carriers for the status, error and arbitration block
package isea_pkg;

  // Five-bit status values as they sit in bits 7..3 of the status byte
  localparam logic [4:0] STAT_NO_INFO    = 5'h1f;   // Byte 0xf8
  localparam logic [4:0] STAT_BUS_ERROR  = 5'h00;   // Byte 0x00
  localparam logic [4:0] STAT_ARB_SLA_R  = 5'h16;   // Byte 0xb0

  // Status byte layout
  localparam int         STAT_MSB        = 7;
  localparam int         STAT_LSB        = 3;
  localparam logic       STAT_RSVD_VAL   = 1'b0;    // Bit 2 reads zero
  localparam logic [1:0] PRESC_MASKED    = 2'h0;    // Prescaler masked away

  // Bit slots within a byte frame, counted on SCL falling edges
  localparam logic [3:0] SLOT_FIRST      = 4'h0;
  localparam logic [3:0] SLOT_LAST_DATA  = 4'h7;
  localparam logic [3:0] SLOT_ACK        = 4'h8;
  localparam logic [3:0] SLOT_STEP       = 4'h1;

  // Idle level of the two bus wires
  localparam logic [1:0] PINS_IDLE       = 2'h3;

  // Control bits as written by software in one access
  typedef struct packed {
    logic done_clear;   // Write one clears the transfer-done flag
    logic ack_enable;
    logic start_req;
    logic stop_req;
  } isea_ctrl_s;

  // Bus events raised at the link side
  typedef struct packed {
    logic bus_err;
    logic addr_r;
    logic addr_w;
    logic arb_lost;
  } isea_evt_s;

  // Commands passed from the core side to the link side
  typedef struct packed {
    logic recover;
    logic clear;
  } isea_cmd_s;

  // Role of the link logic on the bus
  typedef enum logic [2:0] {
    ROLE_NOT_ADDR,
    ROLE_LOST,
    ROLE_LOST_ADDR,
    ROLE_ADDRESSED,
    ROLE_ERROR
  } isea_role_e;

  // Link-side state
  typedef struct packed {
    logic       sda_d;
    logic       scl_d;
    logic       busy;
    logic       in_frame;
    logic       armed;
    logic [3:0] slot;
    logic       addr_phase;
    isea_role_e role;
    logic [7:0] shreg;
    logic       ack_drive;
    logic       hold_scl;
  } isea_link_s;

  // Core-side state
  typedef struct packed {
    logic       flag;
    logic [4:0] status5;
    logic       stop_req;
    logic       start_req;
    logic       ack_en;
    logic [7:0] status_out;
    logic [7:0] status_masked;
  } isea_core_s;

endpackage : isea_pkg

// *** design/isea_sync.sv ***
// Two-flop level synchroniser for a bus of bits
`timescale 1ns/1ps
`default_nettype none

module isea_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,   // Destination clock
  input  wire logic         srst,  // Sync reset, active high
  input  wire logic [W-1:0] d,     // Asynchronous input
  output logic      [W-1:0] q      // Synchronised output
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= RST;
      q      <= RST;
    end
    else
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : isea_sync

`default_nettype wire

// *** design/isea_event_xfer.sv ***
// Toggle-based crossing of single-cycle events between two clocks
`timescale 1ns/1ps
`default_nettype none

module isea_event_xfer #(
  parameter int W = 1
) (
  input  wire logic         src_clk,    // Source clock
  input  wire logic         src_srst,   // Source sync reset
  input  wire logic [W-1:0] src_pulse,  // One-cycle events, source side
  input  wire logic         dst_clk,    // Destination clock
  input  wire logic         dst_srst,   // Destination sync reset
  output logic      [W-1:0] dst_pulse   // One-cycle events, destination side
);

  genvar i;

  // Events closer than three destination cycles may merge
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic tog;
      logic s1;
      logic s2;
      logic s3;

      // Source toggles once per event
      always_ff @(posedge src_clk)
      begin
        if (src_srst)
          tog <= 1'b0;
        else
          tog <= tog ^ src_pulse[i];
      end

      // Two flops, then an edge stage
      always_ff @(posedge dst_clk)
      begin
        if (dst_srst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end
        else
        begin
          s1 <= tog;
          s2 <= s1;
          s3 <= s2;
        end
      end

      assign dst_pulse[i] = s2 ^ s3;
    end
  endgenerate

endmodule : isea_event_xfer

`default_nettype wire

// *** design/isea_top.sv ***
// Status reporting, bus-error recovery and arbitration for the two-wire interface
`timescale 1ns/1ps
`default_nettype none

// Function
// - Status 0xf8 whenever done flag clear
// - No-info status between states and idle
// - Status 0x00 on detected bus error
// - Misplaced START or STOP is bus error
// - Bus error sets the done flag
// - Recovery: not-addressed slave, stop bit cleared
// - Recovery releases lines, sends no STOP
// - Status compared with prescaler masked
// - Repeated start turns direction, not STOP
// - Ownership kept after a repeated start
// - Identical masters see no contention
// - Released-high SDA read low loses
// - After loss: unaddressed slave or new START
// - Loss in address: listen as slave
// - Addressed after loss: follow read/write bit
// - Status bits 7..3, zero, prescaler 1..0
module isea_top #(
  parameter logic [7:0] ARB_LOST_CODE  = 8'h38,  // Loss, not addressed
  parameter logic [7:0] ARB_SLA_W_CODE = 8'h68   // Loss, own write address
) (
  input  wire logic                 clk,            // Core clock
  input  wire logic                 srst,           // Core sync reset
  input  wire logic                 link_clk,       // Bus-side clock
  input  wire logic                 link_srst,      // Bus-side sync reset
  input  wire logic                 ctrl_wr,        // Control write strobe
  input  wire isea_pkg::isea_ctrl_s ctrl_wdata,     // Control write data
  input  wire logic [6:0]           own_addr,       // Own slave address
  input  wire logic [1:0]           prescaler,      // Prescaler bits
  output logic                      transfer_done_flag, // Job done flag
  output logic                      stop_request_bit,   // Stop request
  output logic                      start_request_bit,  // Start request
  output logic                      ack_enable_bit,     // Ack enable
  output logic [7:0]                status_register,    // Full status byte
  output logic [7:0]                status_masked,      // Prescaler masked
  input  wire logic                 master_active,  // Master engine owns bus
  input  wire logic                 master_sda_oe,  // Master pulls SDA low
  input  wire logic                 master_scl_oe,  // Master pulls SCL low
  input  wire logic                 sda_i,          // SDA pin level
  input  wire logic                 scl_i,          // SCL pin level
  output logic                      sda_o,          // SDA drive value
  output logic                      sda_oe,         // SDA drive enable
  output logic                      scl_o,          // SCL drive value
  output logic                      scl_oe,         // SCL drive enable
  output logic                      arb_lost,       // Master must back off
  output logic                      start_grant     // Bus free, send START
);

  localparam int EVT_W = $bits(isea_pkg::isea_evt_s);
  localparam int CMD_W = $bits(isea_pkg::isea_cmd_s);

  isea_pkg::isea_core_s q;
  isea_pkg::isea_core_s next_q;
  isea_pkg::isea_link_s l;
  isea_pkg::isea_link_s next_l;
  isea_pkg::isea_evt_s  ev_link;
  isea_pkg::isea_evt_s  ev_core;
  isea_pkg::isea_cmd_s  cmd_core;
  isea_pkg::isea_cmd_s  cmd_link;
  logic [1:0]           pins_s;
  logic                 sda_s;
  logic                 scl_s;
  logic [6:0]           own_addr_s;
  logic                 ack_en_s;
  logic                 start_req_s;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_c;
  logic                 stop_c;
  logic                 drive_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  // Pins pass two flops before any decode
  isea_sync #(.W(2), .RST(isea_pkg::PINS_IDLE)) u_pin_sync (
    .clk  (link_clk),
    .srst (link_srst),
    .d    ({sda_i, scl_i}),
    .q    (pins_s)
  );

  // Address is quasi-static; software changes it only while idle
  isea_sync #(.W(9), .RST(9'h000)) u_cfg_sync (
    .clk  (link_clk),
    .srst (link_srst),
    .d    ({own_addr, q.ack_en, q.start_req}),
    .q    ({own_addr_s, ack_en_s, start_req_s})
  );

  isea_event_xfer #(.W(EVT_W)) u_evt_xfer (
    .src_clk   (link_clk),
    .src_srst  (link_srst),
    .src_pulse (ev_link),
    .dst_clk   (clk),
    .dst_srst  (srst),
    .dst_pulse (ev_core)
  );
  isea_event_xfer #(.W(CMD_W)) u_cmd_xfer (
    .src_clk   (clk),
    .src_srst  (srst),
    .src_pulse (cmd_core),
    .dst_clk   (link_clk),
    .dst_srst  (link_srst),
    .dst_pulse (cmd_link)
  );
  assign sda_s = pins_s[1];
  assign scl_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Link side: frame tracking, bus errors, arbitration

  // Line events seen on the synchronised wires
  assign scl_rise = scl_s & ~l.scl_d;
  assign scl_fall = ~scl_s & l.scl_d;
  assign start_c  = l.scl_d & scl_s & l.sda_d & ~sda_s;
  assign stop_c   = l.scl_d & scl_s & ~l.sda_d & sda_s;

  always_comb
  begin
    next_l       = l;
    ev_link      = '0;
    next_l.sda_d = sda_s;
    next_l.scl_d = scl_s;
    if (cmd_link.recover)
    begin
      next_l.role      = isea_pkg::ROLE_NOT_ADDR;
      next_l.ack_drive = 1'b0;
      next_l.hold_scl  = 1'b0;
      next_l.in_frame  = 1'b0;
    end
    else if (cmd_link.clear)
      next_l.hold_scl = 1'b0;
    if (start_c || stop_c)
    begin
      next_l.busy       = start_c;
      next_l.slot       = isea_pkg::SLOT_FIRST;
      next_l.armed      = 1'b0;
      next_l.addr_phase = start_c;
      // Misplaced condition inside a byte or ack
      if (l.in_frame && (l.slot != isea_pkg::SLOT_FIRST))
      begin
        ev_link.bus_err  = 1'b1;
        next_l.in_frame  = 1'b0;
        next_l.role      = isea_pkg::ROLE_ERROR;
        next_l.ack_drive = 1'b0;
        next_l.hold_scl  = 1'b0;
      end
      else
      begin
        // Restart at slot 0 keeps role
        next_l.in_frame = start_c;
        if (stop_c && (l.role != isea_pkg::ROLE_ERROR))
        begin
          next_l.role      = isea_pkg::ROLE_NOT_ADDR;
          next_l.ack_drive = 1'b0;
          next_l.hold_scl  = 1'b0;
        end
      end
    end
    else if (l.in_frame)
    begin
      if (scl_rise && l.armed)
      begin
        next_l.shreg = {l.shreg[6:0], sda_s};
        // Compare each sent bit with the wire
        if (master_active && (l.role == isea_pkg::ROLE_NOT_ADDR) &&
            (l.slot <= isea_pkg::SLOT_LAST_DATA) && !master_sda_oe && !sda_s)
        begin
          if (l.addr_phase)
            next_l.role = isea_pkg::ROLE_LOST_ADDR;
          else
          begin
            next_l.role      = isea_pkg::ROLE_LOST;
            ev_link.arb_lost = 1'b1;
          end
        end
      end
      if (scl_fall)
      begin
        if (!l.armed)
          next_l.armed = 1'b1;
        else if (l.slot == isea_pkg::SLOT_ACK)
        begin
          next_l.slot       = isea_pkg::SLOT_FIRST;
          next_l.addr_phase = 1'b0;
          next_l.ack_drive  = 1'b0;
          // Stretch SCL until software answers
          next_l.hold_scl   = l.ack_drive;
        end
        else
          next_l.slot = l.slot + isea_pkg::SLOT_STEP;
        // Loss in address: check own address
        if (l.armed && (l.slot == isea_pkg::SLOT_LAST_DATA) &&
            (l.role == isea_pkg::ROLE_LOST_ADDR))
        begin
          if ((l.shreg[7:1] == own_addr_s) && ack_en_s)
          begin
            next_l.role      = isea_pkg::ROLE_ADDRESSED;
            next_l.ack_drive = 1'b1;
            ev_link.addr_r   = l.shreg[0];
            ev_link.addr_w   = ~l.shreg[0];
          end
          else
          begin
            next_l.role      = isea_pkg::ROLE_LOST;
            ev_link.arb_lost = 1'b1;
          end
        end
      end
    end
  end

  // Link-side state register
  always_ff @(posedge link_clk)
  begin
    if (link_srst)
    begin
      l       <= '0;
      l.sda_d <= 1'b1;
      l.scl_d <= 1'b1;
      l.role  <= isea_pkg::ROLE_NOT_ADDR;
    end
    else
      l <= next_l;
  end

  // Master drive passes only while no loss or error is pending
  always_comb
  begin
    case (l.role)
      // Matching bits never flag a loss
      isea_pkg::ROLE_NOT_ADDR: drive_ok = master_active;
      default:                 drive_ok = 1'b0;
    endcase
  end

  // Open-drain wires: only low is ever driven
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe   = (drive_ok & master_sda_oe) | l.ack_drive;
  assign scl_oe   = (drive_ok & master_scl_oe) | l.hold_scl;
  assign arb_lost = (l.role != isea_pkg::ROLE_NOT_ADDR);

  // New START only once the bus is free
  assign start_grant = start_req_s & ~l.busy & ~master_active & ~start_c &
                       (l.role != isea_pkg::ROLE_ERROR);

  ////////////////////////////////////////////////////////////////////////////
  // Core side: control bits, done flag, status byte

  always_comb
  begin
    next_q   = q;
    cmd_core = '0;
    if (ctrl_wr)
    begin
      next_q.ack_en    = ctrl_wdata.ack_enable;
      next_q.start_req = ctrl_wdata.start_req;
      next_q.stop_req  = ctrl_wdata.stop_req;
      if (ctrl_wdata.done_clear && q.flag)
      begin
        next_q.flag    = 1'b0;
        cmd_core.clear = 1'b1;
        // Stop request with flag clear recovers from bus error
        if ((q.status5 == isea_pkg::STAT_BUS_ERROR) && ctrl_wdata.stop_req)
        begin
          next_q.stop_req  = 1'b0;
          cmd_core.recover = 1'b1;
        end
      end
    end
    // Events set the flag; set wins over clear
    if (|ev_core)
    begin
      next_q.flag = 1'b1;
      // Bus error code has top priority
      if (ev_core.bus_err)
        next_q.status5 = isea_pkg::STAT_BUS_ERROR;
      else if (ev_core.addr_r)
        next_q.status5 = isea_pkg::STAT_ARB_SLA_R;
      else if (ev_core.addr_w)
        next_q.status5 = ARB_SLA_W_CODE[isea_pkg::STAT_MSB:isea_pkg::STAT_LSB];
      else
        next_q.status5 = ARB_LOST_CODE[isea_pkg::STAT_MSB:isea_pkg::STAT_LSB];
    end
    // No information while the flag is clear
    // Covers idle and gaps between states
    next_q.status_out = {(next_q.flag ? next_q.status5 : isea_pkg::STAT_NO_INFO),
                         isea_pkg::STAT_RSVD_VAL, prescaler};
    next_q.status_masked = {next_q.status_out[isea_pkg::STAT_MSB:isea_pkg::STAT_LSB],
                            isea_pkg::STAT_RSVD_VAL, isea_pkg::PRESC_MASKED};
  end

  // Core-side state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q               <= '0;
      q.status5       <= isea_pkg::STAT_NO_INFO;
      q.status_out    <= {isea_pkg::STAT_NO_INFO, isea_pkg::STAT_RSVD_VAL,
                          isea_pkg::PRESC_MASKED};
      q.status_masked <= {isea_pkg::STAT_NO_INFO, isea_pkg::STAT_RSVD_VAL,
                          isea_pkg::PRESC_MASKED};
    end
    else
      q <= next_q;
  end

  // Register-backed software view
  assign transfer_done_flag = q.flag;
  assign stop_request_bit   = q.stop_req;
  assign start_request_bit  = q.start_req;
  assign ack_enable_bit     = q.ack_en;
  assign status_register    = q.status_out;
  assign status_masked      = q.status_masked;

endmodule : isea_top

`default_nettype wire

// *** tb/isea_checker.sv ***
// Property checker for the status, error and arbitration block
`timescale 1ns/1ps
`default_nettype none

module isea_checker (
  input wire logic                 clk,                // Core clock
  input wire logic                 srst,               // Core reset
  input wire logic                 link_clk,           // Link clock
  input wire logic                 link_srst,          // Link reset
  input wire logic                 ctrl_wr,            // Write strobe
  input wire isea_pkg::isea_ctrl_s ctrl_wdata,         // Write data
  input wire logic [1:0]           prescaler,          // Prescaler in
  input wire logic                 transfer_done_flag, // Done flag
  input wire logic                 stop_request_bit,   // Stop bit
  input wire logic                 start_request_bit,  // Start bit
  input wire logic                 ack_enable_bit,     // Ack bit
  input wire logic [7:0]           status_register,    // Status byte
  input wire logic [7:0]           status_masked,      // Masked byte
  input wire logic                 sda_oe,             // SDA pull
  input wire logic                 scl_oe,             // SCL pull
  input wire logic                 arb_lost            // Backed off
);
  logic rec; // Recovery write that the block must honour
  assign rec = ctrl_wr && ctrl_wdata.done_clear && ctrl_wdata.stop_req
               && !ctrl_wdata.start_req && transfer_done_flag && status_masked == 8'h00;

  a_no_info_idle :
  assert property (@(posedge clk) disable iff (srst)
    !transfer_done_flag && !$past(transfer_done_flag) |-> status_masked == 8'hf8)
    else $error("status not f8 while flag clear");
  a_presc_layout :
  assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> status_register[1:0] == $past(prescaler) && !status_register[2])
    else $error("prescaler field or zero bit wrong");
  a_masked_view :
  assert property (@(posedge clk) disable iff (srst)
    status_masked == {status_register[7:3], 3'h0})
    else $error("masked status differs");
  a_error_flag :
  assert property (@(posedge clk) disable iff (srst)
    status_masked == 8'h00 |-> transfer_done_flag)
    else $error("bus error code without flag");
  a_clear_flag :
  assert property (@(posedge clk) disable iff (srst)
    ctrl_wr && ctrl_wdata.done_clear && transfer_done_flag |=> !transfer_done_flag)
    else $error("flag not cleared by write");
  a_start_write :
  assert property (@(posedge clk) disable iff (srst)
    ctrl_wr |=> start_request_bit == $past(ctrl_wdata.start_req))
    else $error("start bit not as written");
  a_recover_bits :
  assert property (@(posedge clk) disable iff (srst)
    rec |=> !stop_request_bit && !transfer_done_flag
            && ack_enable_bit == $past(ctrl_wdata.ack_enable))
    else $error("recovery left wrong control bits");
  a_recover_free :
  assert property (@(posedge clk) disable iff (srst)
    rec |-> ##[2:40] (!sda_oe && !scl_oe && !arb_lost))
    else $error("lines not released after recovery");
  a_lost_quiet :
  assert property (@(posedge link_clk) disable iff (link_srst)
    $rose(arb_lost) |-> !sda_oe)
    else $error("SDA still pulled after loss");

  // Main scenarios reached
  c_bus_error : cover property (@(posedge clk) status_masked == 8'h00);
  c_lost_read : cover property (@(posedge clk) status_masked == 8'hb0);
  c_recovered : cover property (@(posedge clk) rec);
endmodule : isea_checker

bind isea_top isea_checker u_chk (.clk, .srst, .link_clk, .link_srst, .ctrl_wr,
  .ctrl_wdata, .prescaler, .transfer_done_flag, .stop_request_bit, .start_request_bit,
  .ack_enable_bit, .status_register, .status_masked, .sda_oe, .scl_oe, .arb_lost);
`default_nettype wire

// *** tb/isea_bus_model.sv ***
// Wired bus with a competing master and the local master engine
`timescale 1ns/1ps
`default_nettype none

module isea_bus_model (
  input  wire logic lclk,          // Link clock
  input  wire logic sda_oe,        // Block pulls SDA
  input  wire logic scl_oe,        // Block pulls SCL
  input  wire logic arb_lost,      // Block backed off
  output logic      sda_i,         // SDA level
  output logic      scl_i,         // SCL level
  output logic      master_active, // Engine owns bus
  output logic      master_sda_oe, // Engine pulls SDA
  output logic      master_scl_oe  // Engine pulls SCL
);
  logic o_sda = 1'b0;    // Other master pulls SDA
  logic o_scl = 1'b0;    // Other master pulls SCL
  logic ack_seen = 1'b0; // SDA low in the ack slot
  // Engine idle until a frame begins
  initial
  begin
    master_active = 1'b0;
    master_sda_oe = 1'b0;
    master_scl_oe = 1'b0;
  end
  // Pull-ups: a line is high unless some party pulls it
  assign sda_i = !(o_sda || sda_oe);
  assign scl_i = !(o_scl || scl_oe);

  task automatic half();
    repeat (4) @(posedge lclk);
  endtask : half
  // Other master takes SCL low to open the next byte
  task automatic pull_scl();
    o_scl <= 1'b1;
    half();
  endtask : pull_scl
  // Start or stop: SDA moves while SCL is high
  task automatic cond(input logic is_stop);
    o_scl <= 1'b1;
    master_sda_oe <= 1'b0;
    half();
    o_sda <= is_stop;
    half();
    o_scl <= 1'b0;
    half();
    o_sda <= !is_stop;
    if (is_stop)
      master_active <= 1'b0;
    half();
  endtask : cond
  task automatic send_bit(input logic ob, input logic mb, input logic mine);
    o_scl <= 1'b1;
    master_scl_oe <= mine;
    half();
    o_sda <= !ob;
    master_sda_oe <= mine && !mb && !arb_lost;
    half();
    o_scl <= 1'b0;
    master_scl_oe <= 1'b0;
    half();
    ack_seen <= !sda_i;
    half();
  endtask : send_bit
  // frame may follow a repeated start
  task automatic frame(input logic [7:0] ob, input logic [7:0] mb, input logic mine);
    cond(1'b0);
    master_active <= mine;
    for (int i = 7; i >= 0; i--)
      send_bit(ob[i], mb[i], mine);
    send_bit(1'b1, 1'b1, 1'b0);
  endtask : frame
endmodule : isea_bus_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the status, error and arbitration block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] LOST_C = 8'h38; // Loss, not addressed
  localparam logic [7:0] SLAW_C = 8'h68; // Loss, own write address
  logic                 clk = 1'b0;
  logic                 link_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 link_srst = 1'b1;
  logic                 ctrl_wr = 1'b0;
  isea_pkg::isea_ctrl_s ctrl_wdata = '0;
  logic [6:0]           own_addr = 7'h00;
  logic [1:0]           prescaler = 2'h0;
  logic                 flag, stop_b, start_b, ack_b, sda_oe, scl_oe, lost, grant;
  logic                 sda_i, scl_i, m_act, m_sda, m_scl, sd_o, sc_o;
  logic [7:0]           status, masked, ob, mb;
  logic [2:0]           r;
  int                   err_count = 0;
  int                   num_checks = 0;

  always #5 clk = !clk;
  // Link clock offset so the two never line up
  initial
  begin
    #2.3;
    forever #7.5 link_clk = !link_clk;
  end

  isea_top #(.ARB_LOST_CODE(LOST_C), .ARB_SLA_W_CODE(SLAW_C)) uut (
    .clk(clk), .srst(srst), .link_clk(link_clk), .link_srst(link_srst),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .own_addr(own_addr), .prescaler(prescaler),
    .transfer_done_flag(flag), .stop_request_bit(stop_b), .start_request_bit(start_b),
    .ack_enable_bit(ack_b), .status_register(status), .status_masked(masked),
    .master_active(m_act), .master_sda_oe(m_sda), .master_scl_oe(m_scl),
    .sda_i(sda_i), .scl_i(scl_i), .sda_o(sd_o), .sda_oe(sda_oe), .scl_o(sc_o), .scl_oe(scl_oe),
    .arb_lost(lost), .start_grant(grant));
  isea_bus_model bus (.lclk(link_clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .arb_lost(lost),
    .sda_i(sda_i), .scl_i(scl_i), .master_active(m_act), .master_sda_oe(m_sda),
    .master_scl_oe(m_scl));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One control write, then let it land
  task automatic wr(input logic dc, input logic ae, input logic sa, input logic sp);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= {dc, ae, sa, sp};
    @(posedge clk);
    ctrl_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Bounded wait for the flag plus the status lag
  task automatic wait_flag();
    for (int i = 0; i < 300 && flag !== 1'b1; i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    chk({7'h0, flag}, 8'h01);
  endtask : wait_flag
  // Expected code after losing in the address byte
  function automatic logic [7:0] exp_code(input logic match, input logic rd);
    return !match ? LOST_C : (rd ? {isea_pkg::STAT_ARB_SLA_R, 3'h0} : SLAW_C);
  endfunction : exp_code
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Watchdog cuts a hung run short
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h3caa));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    link_srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(masked, 8'hf8);
    chk({flag, stop_b, start_b, ack_b}, 8'h00);
    // Random control bits and prescaler while idle
    for (int i = 0; i < 8; i++)
    begin
      r = 3'($urandom);
      prescaler <= r[1:0];
      wr(1'b0, r[2], r[0], r[1]);
      chk({ack_b, stop_b, start_b}, r);
      chk(status, {isea_pkg::STAT_NO_INFO, 1'b0, r[1:0]});
    end
    wr(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test control done");
    // Start inside a byte, then recovery
    bus.cond(1'b0);
    repeat (3) bus.send_bit(1'($urandom), 1'b1, 1'b0);
    bus.cond(1'b0);
    wait_flag();
    chk(masked, 8'h00);
    bus.cond(1'b1);
    r = 3'($urandom);
    wr(1'b1, r[0], 1'b0, 1'b1);
    chk({flag, stop_b, ack_b}, {2'h0, r[0]});
    chk(masked, 8'hf8);
    repeat (20) @(posedge clk);
    chk({sda_oe, scl_oe, lost, sd_o, sc_o}, 5'h0);
    wr(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test bus error done");
    // Loss in the address: own read, own write, other address
    own_addr <= 7'($urandom) & 7'h3f;
    @(posedge clk);
    for (int c = 0; c < 3; c++)
    begin
      ob = (c == 2) ? {own_addr ^ 7'h01, 1'b1} : {own_addr, c == 0};
      mb = 8'h80 | 8'($urandom);
      bus.frame(ob, mb, 1'b1);
      // Next byte opens; an addressed loser stretches SCL
      bus.pull_scl();
      wait_flag();
      chk(masked, exp_code(c < 2, c == 0));
      chk({7'h0, bus.ack_seen}, {7'h0, c < 2});
      chk({7'h0, lost}, 8'h01);
      wr(1'b1, 1'b1, 1'b0, 1'b0);
      bus.cond(1'b1);
      repeat (10) @(posedge clk);
      chk({flag, lost}, 2'h0);
    end
    wr(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk({7'h0, grant}, 8'h01);
    wr(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test arbitration done");
    // Identical masters, repeated start keeps the bus
    ob = {own_addr ^ 7'h40, 1'b0};
    bus.frame(ob, ob, 1'b1);
    chk({flag, lost}, 2'h0);
    ob = 8'($urandom);
    bus.frame(ob, ob, 1'b1);
    chk({flag, lost, m_act}, 3'h1);
    // Data byte lost to the other master after the restart
    ob = 8'h7f & 8'($urandom);
    for (int i = 7; i >= 0; i--)
      bus.send_bit(ob[i], 1'b1, 1'b1);
    bus.send_bit(1'b1, 1'b1, 1'b0);
    wait_flag();
    chk(masked, LOST_C);
    chk({7'h0, lost}, 8'h01);
    wr(1'b1, 1'b1, 1'b0, 1'b0);
    bus.cond(1'b1);
    repeat (10) @(posedge clk);
    chk(masked, 8'hf8);
    $display("test repeated start done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
